/* File: rtl/sma_pkg.sv */
package sma_pkg;
	localparam int          SMA_NUM_WARN   = 8;
	localparam int          SMA_ADDR_W     = 7;
	localparam int          SMA_BYTE_BITS  = 8;
	localparam int          SMA_NUM_PINS   = 2;
	localparam logic [7:0]  SMA_STATUS_RST = 8'h00;
	localparam logic [1:0]  SMA_ALERT_RST  = 2'h0;
	localparam logic [3:0]  SMA_CNT_RST    = 4'h0;
	localparam logic [3:0]  SMA_CNT_LAST   = 4'h7;
	localparam logic [6:0]  SMA_ARA_ADDR   = 7'h0C;

	typedef enum logic [2:0] {
		SMA_ARA_IDLE = 3'b001,
		SMA_ARA_SEND = 3'b010,
		SMA_ARA_ACK  = 3'b100
	} sma_ara_state_e;
endpackage

/* File: rtl/sma_ara_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module sma_ara_tx (
	// clock and reset
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	// request
	input  wire logic                        start_i,
	input  wire logic                        pending_i,
	input  wire logic [sma_pkg::SMA_ADDR_W-1:0] dev_addr_i,
	// bit timing from the bus engine
	input  wire logic                        drive_tick_i,
	input  wire logic                        sample_tick_i,
	input  wire logic                        sda_i,
	// results
	output logic                             sda_oe_o,
	output logic                             win_o,
	output logic                             lost_o,
	output logic                             busy_o
);
	import sma_pkg::*;

	sma_ara_state_e state_reg, state_next;
	logic [7:0]     shift_reg, shift_next;
	logic [3:0]     cnt_reg,   cnt_next;
	logic           smp_reg,   smp_next;
	logic           win_next,  lost_next;

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		cnt_next   = cnt_reg;
		smp_next   = smp_reg;
		win_next   = 1'b0;
		lost_next  = 1'b0;
		case (state_reg)
			SMA_ARA_IDLE: begin
				if (start_i && pending_i) begin
					// lsb is don't-care, sent as 1 so it never wins arbitration by itself
					shift_next = {dev_addr_i, 1'b1};
					cnt_next   = SMA_CNT_RST;
					smp_next   = 1'b0;
					state_next = SMA_ARA_SEND;
				end
			end
			SMA_ARA_SEND: begin
				if (sample_tick_i && !smp_reg) begin
					if (shift_reg[7] && !sda_i) begin
						lost_next  = 1'b1;
						state_next = SMA_ARA_IDLE;
					end else begin
						smp_next = 1'b1;
					end
				end else if (drive_tick_i && smp_reg) begin
					// shift only while scl is low so sda never moves during high
					smp_next   = 1'b0;
					shift_next = {shift_reg[6:0], 1'b1};
					cnt_next   = cnt_reg + 4'h1;
					if (cnt_reg == SMA_CNT_LAST) begin
						state_next = SMA_ARA_ACK;
					end
				end
			end
			SMA_ARA_ACK: begin
				if (sample_tick_i) begin
					win_next   = sda_i;
					state_next = SMA_ARA_IDLE;
				end
			end
			default: begin
				state_next = SMA_ARA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= SMA_ARA_IDLE;
			shift_reg <= SMA_STATUS_RST;
			cnt_reg   <= SMA_CNT_RST;
			smp_reg   <= 1'b0;
			win_o     <= 1'b0;
			lost_o    <= 1'b0;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			cnt_reg   <= cnt_next;
			smp_reg   <= smp_next;
			win_o     <= win_next;
			lost_o    <= lost_next;
		end
	end

	assign sda_oe_o = (state_reg == SMA_ARA_SEND) && !shift_reg[7];
	assign busy_o   = (state_reg != SMA_ARA_IDLE);

	property p_lost_stops;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		lost_o |-> !sda_oe_o ##1 !sda_oe_o;
	endproperty
	a_lost_stops: assert property (p_lost_stops) else $error("drove sda after losing");

	property p_win_after_nack;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		win_o |-> $past(sda_i) && !busy_o && !sda_oe_o;
	endproperty
	a_win_after_nack: assert property (p_win_after_nack) else $error("win without nack");
endmodule // sma_ara_tx
`default_nettype wire

/* File: rtl/sma_alert.sv */
`timescale 1ns/1ps
`default_nettype none
module sma_alert (
	// clock and reset
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	// warning events and live comparisons
	input  wire logic [sma_pkg::SMA_NUM_WARN-1:0] warn_set_i,
	input  wire logic [sma_pkg::SMA_NUM_WARN-1:0] warn_above_i,
	input  wire logic                          clear_faults_i,
	output logic [sma_pkg::SMA_NUM_WARN-1:0]   status_o,
	// configuration
	input  wire logic [sma_pkg::SMA_NUM_WARN-1:0] alert_source_select_i,
	input  wire logic [sma_pkg::SMA_NUM_WARN-1:0] second_alert_source_select_i,
	input  wire logic [sma_pkg::SMA_NUM_PINS-1:0] invert_i,
	input  wire logic [sma_pkg::SMA_NUM_PINS-1:0] comparator_mode_i,
	input  wire logic                          conversion_trigger_input_mode_i,
	// multifunction pins, open drain
	input  wire logic                          multifunction_pin_one_i,
	output logic                               multifunction_pin_one_o,
	output logic                               multifunction_pin_one_oe_o,
	output logic                               multifunction_pin_two_o,
	output logic                               multifunction_pin_two_oe_o,
	output logic                               conversion_trigger_o,
	// alert response read
	input  wire logic [sma_pkg::SMA_ADDR_W-1:0] dev_addr_i,
	input  wire logic                          ara_start_i,
	input  wire logic                          ara_drive_tick_i,
	input  wire logic                          ara_sample_tick_i,
	input  wire logic                          ara_sda_i,
	output logic                               ara_sda_oe_o,
	output logic                               ara_busy_o,
	output logic [sma_pkg::SMA_NUM_PINS-1:0]   alert_pending_o
);
	import sma_pkg::*;

	logic [SMA_NUM_WARN-1:0] status_reg, status_next, status_kept, rise;
	logic [SMA_NUM_PINS-1:0] alert_reg, alert_next, oe_reg, oe_next, active_next;
	logic [SMA_NUM_WARN-1:0] en [SMA_NUM_PINS];
	logic                    pin_one_prev_reg, conversion_trigger_input_next;
	logic                    ara_win, ara_lost;

	assign en[0] = alert_source_select_i;
	assign en[1] = second_alert_source_select_i;

	// set beats clear: an event landing on the clear cycle survives
	always_comb begin
		status_kept = clear_faults_i ? SMA_STATUS_RST : status_reg;
		rise        = warn_set_i & ~status_kept;
		status_next = status_kept | warn_set_i;
	end

	genvar k;
	generate
		for (k = 0; k < SMA_NUM_PINS; k++) begin : g_pin
			logic pin_en;
			assign pin_en = (|en[k]) && !(k == 0 && conversion_trigger_input_mode_i);
			// one shared release term keeps both latched alerts going inactive together
			assign alert_next[k] = (pin_en && |(rise & en[k]))
				| (alert_reg[k] & ~(clear_faults_i | ara_win));
			assign active_next[k] = comparator_mode_i[k]
				? |(warn_above_i & en[k]) : alert_next[k];
			// open drain only pulls low; inverted active level means pull while idle
			assign oe_next[k] = pin_en && (active_next[k] != invert_i[k]);
		end
	endgenerate

	assign conversion_trigger_input_next = conversion_trigger_input_mode_i && pin_one_prev_reg && !multifunction_pin_one_i;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_reg           <= SMA_STATUS_RST;
			alert_reg            <= SMA_ALERT_RST;
			oe_reg               <= SMA_ALERT_RST;
			pin_one_prev_reg     <= 1'b1;
			conversion_trigger_o <= 1'b0;
		end else begin
			status_reg           <= status_next;
			alert_reg            <= alert_next;
			oe_reg               <= oe_next;
			pin_one_prev_reg     <= multifunction_pin_one_i;
			conversion_trigger_o <= conversion_trigger_input_next;
		end
	end

	assign status_o                   = status_reg;
	assign alert_pending_o            = alert_reg;
	assign multifunction_pin_one_o    = 1'b0;
	assign multifunction_pin_two_o    = 1'b0;
	assign multifunction_pin_one_oe_o = oe_reg[0];
	assign multifunction_pin_two_oe_o = oe_reg[1];

	// only latched alerts answer; comparator pins are not alert sources
	sma_ara_tx u_ara (
		.clk_sys_i     (clk_sys_i),
		.rst_n_i       (rst_n_i),
		.start_i       (ara_start_i),
		.pending_i     (|(alert_reg & ~comparator_mode_i)),
		.dev_addr_i    (dev_addr_i),
		.drive_tick_i  (ara_drive_tick_i),
		.sample_tick_i (ara_sample_tick_i),
		.sda_i         (ara_sda_i),
		.sda_oe_o      (ara_sda_oe_o),
		.win_o         (ara_win),
		.lost_o        (ara_lost),
		.busy_o        (ara_busy_o)
	);

	property p_clear_releases;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		clear_faults_i && warn_set_i == 8'h00 |=> alert_reg == 2'h0 && status_reg == 8'h00;
	endproperty
	a_clear_releases: assert property (p_clear_releases) else $error("clear left alert");

	property p_status_latch;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!clear_faults_i |=> (status_reg & $past(status_reg)) == $past(status_reg);
	endproperty
	a_status_latch: assert property (p_status_latch) else $error("status bit dropped");

	property p_rise_asserts;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		|(rise & second_alert_source_select_i) |=> alert_reg[1];
	endproperty
	a_rise_asserts: assert property (p_rise_asserts) else $error("rising bit gave no alert");

	property p_win_holds;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		ara_win && !clear_faults_i && rise == 8'h00
			|=> alert_reg == 2'h0 && status_reg == $past(status_reg);
	endproperty
	a_win_holds: assert property (p_win_holds) else $error("win kept alert");

	property p_lost_keeps;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		ara_lost && !clear_faults_i |=> (alert_reg & $past(alert_reg)) == $past(alert_reg);
	endproperty
	a_lost_keeps: assert property (p_lost_keeps) else $error("loser dropped alert");

	property p_disabled_hiz;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		second_alert_source_select_i == 8'h00 |=> !multifunction_pin_two_oe_o;
	endproperty
	a_disabled_hiz: assert property (p_disabled_hiz) else $error("disabled pin driven");

	property p_cmp_live;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		comparator_mode_i[1] && !invert_i[1] && second_alert_source_select_i != 8'h00
			|=> multifunction_pin_two_oe_o == $past(|(warn_above_i & second_alert_source_select_i));
	endproperty
	a_cmp_live: assert property (p_cmp_live) else $error("comparator not live");

	property p_invert_level;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!comparator_mode_i[1] && alert_next[1] && second_alert_source_select_i != 8'h00
			|=> multifunction_pin_two_oe_o == !$past(invert_i[1]);
	endproperty
	a_invert_level: assert property (p_invert_level) else $error("wrong active level");

	// with no new rise both latched alerts must share one fate
	property p_release_together;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		alert_reg == 2'h3 && rise == 8'h00 |=> alert_reg[0] == alert_reg[1];
	endproperty
	a_release_together: assert property (p_release_together) else $error("pins released apart");

	property p_rise_asserts_one;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		|(rise & alert_source_select_i) && !conversion_trigger_input_mode_i |=> alert_reg[0];
	endproperty
	a_rise_asserts_one: assert property (p_rise_asserts_one) else $error("pin one missed rise");

	property p_set_lands;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		warn_set_i != 8'h00 |=> (status_reg & $past(warn_set_i)) == $past(warn_set_i);
	endproperty
	a_set_lands: assert property (p_set_lands) else $error("warning not latched");

	property p_conversion_trigger_input_no_drive;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		conversion_trigger_input_mode_i |=> !multifunction_pin_one_oe_o;
	endproperty
	a_conversion_trigger_input_no_drive: assert property (p_conversion_trigger_input_no_drive) else $error("input pin driven");

	property p_conversion_trigger_input_pulse;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		conversion_trigger_o |=> !conversion_trigger_o;
	endproperty
	a_conversion_trigger_input_pulse: assert property (p_conversion_trigger_input_pulse) else $error("trigger longer than one cycle");

	property p_ara_busy;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		ara_start_i && !ara_busy_o && |(alert_reg & ~comparator_mode_i) |=> ara_busy_o;
	endproperty
	a_ara_busy: assert property (p_ara_busy) else $error("pending alert gave no answer");

	property p_cmp_live_one;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		comparator_mode_i[0] && !invert_i[0] && !conversion_trigger_input_mode_i && alert_source_select_i != 8'h00
			|=> multifunction_pin_one_oe_o == $past(|(warn_above_i & alert_source_select_i));
	endproperty
	a_cmp_live_one: assert property (p_cmp_live_one) else $error("pin one comparator not live");

	property p_disabled_hiz_one;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		alert_source_select_i == 8'h00 |=> !multifunction_pin_one_oe_o;
	endproperty
	a_disabled_hiz_one: assert property (p_disabled_hiz_one) else $error("disabled pin one driven");
endmodule // sma_alert
`default_nettype wire

/* File: testbench/sma_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sma_host_model (
	// clock
	input  wire logic clk_sys_i,
	// device pulls sda low
	input  wire logic dev_sda_oe_i,
	// bus engine view of the read
	output logic      ara_start_o,
	output logic      drive_tick_o,
	output logic      sample_tick_o,
	output logic      sda_o
);
	logic [7:0] rival_byte;
	logic       rival_on;
	int         bit_idx;

	// wired and with pull-up; host never pulls, so the ack slot reads as nack
	assign sda_o = !(dev_sda_oe_i || (rival_on && bit_idx < 8 && !rival_byte[7 - bit_idx]));

	initial begin
		ara_start_o = 1'b0;
		drive_tick_o = 1'b0;
		sample_tick_o = 1'b0;
		rival_on = 1'b0;
		bit_idx = 8;
	end

	// receive byte at the alert response address, optional lower rival
	task automatic run_ara(input logic [6:0] rival_addr, input logic rival_en,
		output logic [7:0] got);
		rival_byte = {rival_addr, 1'b1};
		rival_on = rival_en;
		bit_idx = 0;
		@(negedge clk_sys_i);
		ara_start_o = 1'b1;
		@(negedge clk_sys_i);
		ara_start_o = 1'b0;
		for (int i = 0; i < 9; i++) begin
			bit_idx = i;
			sample_tick_o = 1'b1;
			// read after the sampling edge has settled, bit is held until the drive tick
			@(negedge clk_sys_i);
			if (i < 8) got[7 - i] = sda_o;
			sample_tick_o = 1'b0;
			drive_tick_o = (i < 8);
			@(negedge clk_sys_i);
			drive_tick_o = 1'b0;
		end
		rival_on = 1'b0;
	endtask
endmodule // sma_host_model
`default_nettype wire

/* File: testbench/sma_alert_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sma_alert_tb;
	import sma_pkg::*;
	logic       clk_sys_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [7:0] wset, wabove, sel1, sel2, status, got;
	logic [1:0] inv, cmp, pend;
	logic [6:0] addr;
	logic       clr, conversion_trigger_input, pin_in, p1, p1oe, p2, p2oe, trig, start, dtk, stk, sda, sda_oe, busy;
	int         failures = 0;
	int         num_checks = 0;
	int         cyc = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	sma_alert sma_alert_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .warn_set_i(wset),
		.warn_above_i(wabove), .clear_faults_i(clr), .status_o(status),
		.alert_source_select_i(sel1), .second_alert_source_select_i(sel2), .invert_i(inv),
		.comparator_mode_i(cmp), .conversion_trigger_input_mode_i(conversion_trigger_input), .multifunction_pin_one_i(pin_in),
		.multifunction_pin_one_o(p1), .multifunction_pin_one_oe_o(p1oe),
		.multifunction_pin_two_o(p2), .multifunction_pin_two_oe_o(p2oe),
		.conversion_trigger_o(trig), .dev_addr_i(addr), .ara_start_i(start),
		.ara_drive_tick_i(dtk), .ara_sample_tick_i(stk), .ara_sda_i(sda),
		.ara_sda_oe_o(sda_oe), .ara_busy_o(busy), .alert_pending_o(pend));

	sma_host_model sma_host_model_i (.clk_sys_i(clk_sys_i), .dev_sda_oe_i(sda_oe),
		.ara_start_o(start), .drive_tick_o(dtk), .sample_tick_o(stk), .sda_o(sda));

	task automatic close_out();
		if (failures == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// generous ceiling, whole run is under a hundred cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			close_out();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task automatic pins(input logic [1:0] e);
		chk({4'h0, p2, p1, p2oe, p1oe}, {4'h0, 2'b00, e});
	endtask

	task automatic raise(input logic [7:0] w);
		wset = w;
		step(1);
		wset = 8'h00;
		step(1);
	endtask

	task automatic pulse_clr();
		clr = 1'b1;
		step(1);
		clr = 1'b0;
		step(1);
	endtask

	task automatic t_latch();
		sel1 = 8'h01;
		sel2 = 8'h04;
		raise(8'h04);
		chk(status, 8'h04);
		pins(2'b10);
		raise(8'h01);
		step(2);
		chk(status, 8'h05);
		chk({6'h00, pend}, 8'h03);
		pulse_clr();
		chk(status, 8'h00);
		pins(2'b00);
	endtask

	task automatic t_persist();
		wset = 8'h04;
		pulse_clr();
		chk(status, 8'h04);
		pins(2'b10);
		wset = 8'h00;
		pulse_clr();
	endtask

	task automatic t_ara();
		raise(8'h04);
		sma_host_model_i.run_ara(7'h15, 1'b1, got);
		chk(got, 8'h2B);
		step(1);
		pins(2'b10);
		chk({7'h00, busy}, 8'h00);
		sma_host_model_i.run_ara(7'h00, 1'b0, got);
		chk(got, 8'h55);
		step(1);
		pins(2'b00);
		chk({7'h00, busy}, 8'h00);
		chk(status, 8'h04);
		raise(8'h04);
		pins(2'b00);
		raise(8'h01);
		pins(2'b01);
		pulse_clr();
	endtask

	task automatic t_cmp();
		cmp = 2'b11;
		inv = 2'b10;
		sel2 = 8'h02;
		wabove = 8'h01;
		step(1);
		pins(2'b11);
		wabove = 8'h02;
		step(1);
		pins(2'b00);
		wabove = 8'h00;
		step(1);
		pins(2'b10);
		cmp = 2'b00;
		inv = 2'b00;
	endtask

	task automatic t_conversion_trigger_input();
		int n;
		n = 0;
		conversion_trigger_input = 1'b1;
		step(2);
		pin_in = 1'b0;
		wset = 8'h01;
		repeat (3) begin
			step(1);
			wset = 8'h00;
			n += (trig === 1'b1);
		end
		chk(8'(n), 8'h01);
		chk({7'h00, p1oe}, 8'h00);
	endtask

	initial begin
		wset = 8'h00;
		wabove = 8'h00;
		sel1 = 8'h00;
		sel2 = 8'h00;
		inv = 2'b00;
		cmp = 2'b00;
		clr = 1'b0;
		conversion_trigger_input = 1'b0;
		pin_in = 1'b1;
		addr = 7'h2A;
		step(10);
		rst_n_i = 1'b1;
		step(1);
		pins(2'b00);
		chk({6'h00, pend}, 8'h00);
		t_latch();
		t_persist();
		t_ara();
		t_cmp();
		t_conversion_trigger_input();
		close_out();
	end
endmodule // sma_alert_tb
`default_nettype wire
